// ---- ofo_pkg.sv ----
// frame overhead constants, field layout and shared helper functions
// assumes one byte per accepted link beat, 4 rows of 3824 columns
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package ofo_pkg;

  typedef logic [11:0] ofo_col_t;
  typedef logic [1:0]  ofo_row_t;

  localparam ofo_col_t  COL_FIRST    = 12'h001;
  localparam ofo_col_t  COL_FAS_LEAD = 12'h003;
  localparam ofo_col_t  COL_FAS_LAST = 12'h006;
  localparam ofo_col_t  COL_MFAS     = 12'h007;
  localparam ofo_col_t  COL_TTI      = 12'h008;
  localparam ofo_col_t  COL_BIP      = 12'h009;
  localparam ofo_col_t  COL_SM3      = 12'h00a;
  localparam ofo_col_t  COL_OH_LAST  = 12'h00e;
  localparam ofo_col_t  COL_PL_FIRST = 12'h00f;
  localparam ofo_col_t  COL_LAST     = 12'hef0;
  localparam ofo_row_t  ROW_FIRST    = 2'h0;
  localparam ofo_row_t  ROW_LAST     = 2'h3;

  localparam logic [7:0]  FAS_LEAD   = 8'hf6;
  localparam logic [7:0]  FAS_TRAIL  = 8'h28;
  localparam logic [47:0] FAS_WORD   = 48'hf6f6f6282828;
  localparam logic [3:0]  BIAE_CODE  = 4'hb;
  localparam logic [3:0]  BEI_MAX    = 4'h8;
  localparam logic [2:0]  STAT_OK    = 3'h1;
  localparam logic [2:0]  STAT_IAE   = 3'h2;
  localparam logic [2:0]  STAT_AIS   = 3'h7;
  localparam logic [2:0]  MISS_LIMIT = 3'h5;
  localparam int          TTI_LEN    = 64;

  // advance one byte position through the frame, rows wrap naturally
  function automatic logic [13:0] ofo_next_pos(input ofo_col_t col,
                                               input ofo_row_t row);
    if (col == COL_LAST)
      ofo_next_pos = {row + 2'h1, COL_FIRST};
    else
      ofo_next_pos = {row, col + 12'h001};
  endfunction

  // true for the row 1 overhead bytes, columns 1-14
  function automatic logic ofo_is_oh(input ofo_col_t col,
                                     input ofo_row_t row);
    ofo_is_oh = (row == ROW_FIRST) && (col <= COL_OH_LAST);
  endfunction

  // unused codes read as zero errors, no alignment error
  function automatic logic [4:0] ofo_bei_decode(input logic [3:0] code);
    if (code == BIAE_CODE)
      ofo_bei_decode = {1'b1, 4'h0};
    else if (code <= BEI_MAX)
      ofo_bei_decode = {1'b0, code};
    else
      ofo_bei_decode = 5'h00;
  endfunction

endpackage

// ---- ofo_link_if.sv ----
// byte stream between overhead source and overhead sink
// assumes both ends sit on sys_clk; data moves on valid and ready high
`timescale 1ns/1ps
interface ofo_link_if (
  input wire logic sys_clk,
  input wire logic rst_n
);
  logic [7:0] data;
  logic       valid;
  logic       ready;

  modport src (
    output data,
    output valid,
    input  ready
  );

  modport snk (
    input  data,
    input  valid,
    output ready
  );
endinterface

// ---- ofo_src.sv ----
// overhead source: builds row 1 overhead around user payload bytes
// assumes the user offers payload in frame order; own sink feeds status
`timescale 1ns/1ps
module ofo_src
  import ofo_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  ofo_link_if.src          lk,
  input  wire logic [7:0]  pl_data,
  input  wire logic        pl_valid,
  output logic             pl_ready,
  input  wire logic        tti_wr_en,
  input  wire logic [5:0]  tti_wr_addr,
  input  wire logic [7:0]  tti_wr_data,
  input  wire logic        sink_sf,
  input  wire logic        sink_iae,
  input  wire logic [3:0]  sink_bei_cnt,
  input  wire logic        sink_biae,
  input  wire logic        cn_mode,
  input  wire logic        ais_en,
  output logic [7:0]       mfas,
  output logic             frame_start
);

  //--------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------
  ofo_col_t   col_q, col_d;
  ofo_row_t   row_q, row_d;
  logic [7:0] mfas_q, mfas_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] bip1_q, bip1_d;
  logic [7:0] bip2_q, bip2_d;
  logic [7:0] e0_q, e0_d;
  logic [7:0] e1_q, e1_d;
  logic       v0_q, v0_d;
  logic       v1_q, v1_d;
  logic       sof_q, sof_d;
  logic [7:0] tti_mem [TTI_LEN];

  logic       ovh;
  logic       push;
  logic       pop;
  logic [7:0] oh_byte;
  logic [7:0] din;
  logic [3:0] bei_code;
  logic [2:0] stat;
  logic [13:0] nxt;

  //--------------------------------------------------------------------
  // overhead byte selection
  //--------------------------------------------------------------------
  always_comb
  begin
    if (sink_iae)
      bei_code = BIAE_CODE;
    else if (sink_bei_cnt > BEI_MAX)
      bei_code = BEI_MAX;
    else
      bei_code = sink_bei_cnt;
    if (ais_en)
      stat = STAT_AIS;
    else if (sink_iae)
      stat = STAT_IAE;
    else
      stat = STAT_OK;
    // the sink's own backward report; sink_biae is folded into the align error bit outside cn_mode only
    case (col_q)
      12'h001, 12'h002, 12'h003:
        oh_byte = FAS_LEAD;
      12'h004, 12'h005, 12'h006:
        oh_byte = FAS_TRAIL;
      COL_MFAS:
        oh_byte = mfas_q;
      COL_TTI:
        oh_byte = tti_mem[mfas_q[5:0]];
      COL_BIP:
        oh_byte = bip2_q;
      COL_SM3:
        // one defect bit only, in this first field
        if (cn_mode)
          oh_byte = {bei_code, sink_sf, stat};
        else
          oh_byte = {bei_code, sink_sf, sink_iae | sink_biae,
                     2'h0};
      default:
        oh_byte = 8'h00;
    endcase
  end

  // a single monitoring instance: fields 2..n never exist
  assign ovh      = ofo_is_oh(col_q, row_q);
  assign pl_ready = !v1_q && !ovh;
  assign push     = !v1_q && (ovh || pl_valid);
  assign pop      = v0_q && lk.ready;
  assign din      = ovh ? oh_byte : pl_data;
  assign nxt      = ofo_next_pos(col_q, row_q);

  //--------------------------------------------------------------------
  // frame position, multiframe counter and parity
  //--------------------------------------------------------------------
  always_comb
  begin
    col_d  = col_q;
    row_d  = row_q;
    mfas_d = mfas_q;
    acc_d  = acc_q;
    bip1_d = bip1_q;
    bip2_d = bip2_q;
    sof_d  = 1'b0;
    if (push)
    begin
      col_d = nxt[11:0];
      row_d = nxt[13:12];
      if (col_q >= COL_PL_FIRST)
        acc_d = acc_q ^ din;
      if (col_q == COL_LAST && row_q == ROW_LAST)
      begin
        // one shared counter, so every instance sees the same value
        mfas_d = mfas_q + 8'h01;
        bip2_d = bip1_q;
        bip1_d = acc_q ^ din;
        acc_d  = 8'h00;
        sof_d  = 1'b1;
      end
    end
  end

  //--------------------------------------------------------------------
  // two-entry output buffer: link stalls never drop a byte
  //--------------------------------------------------------------------
  always_comb
  begin
    e0_d = e0_q;
    e1_d = e1_q;
    v0_d = v0_q;
    v1_d = v1_q;
    if (pop && push)
    begin
      if (v1_q)
      begin
        e0_d = e1_q;
        e1_d = din;
      end
      else
        e0_d = din;
    end
    else if (pop)
    begin
      e0_d = e1_q;
      v0_d = v1_q;
      v1_d = 1'b0;
    end
    else if (push)
    begin
      if (v0_q)
      begin
        e1_d = din;
        v1_d = 1'b1;
      end
      else
      begin
        e0_d = din;
        v0_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      col_q  <= COL_FIRST;
      row_q  <= ROW_FIRST;
      mfas_q <= 8'h00;
      acc_q  <= 8'h00;
      bip1_q <= 8'h00;
      bip2_q <= 8'h00;
      e0_q   <= 8'h00;
      e1_q   <= 8'h00;
      v0_q   <= 1'b0;
      v1_q   <= 1'b0;
      sof_q  <= 1'b0;
    end
    else
    begin
      col_q  <= col_d;
      row_q  <= row_d;
      mfas_q <= mfas_d;
      acc_q  <= acc_d;
      bip1_q <= bip1_d;
      bip2_q <= bip2_d;
      e0_q   <= e0_d;
      e1_q   <= e1_d;
      v0_q   <= v0_d;
      v1_q   <= v1_d;
      sof_q  <= sof_d;
    end
  end

  // trace message store, no reset: software loads it before use
  always_ff @(posedge sys_clk)
  begin
    if (tti_wr_en)
      tti_mem[tti_wr_addr] <= tti_wr_data;
  end

  assign lk.data     = e0_q;
  assign lk.valid    = v0_q;
  // short multiframes take low bits; 80/20/40-frame phases come elsewhere
  assign mfas        = mfas_q;
  assign frame_start = sof_q;

endmodule // ofo_src

// ---- ofo_snk.sv ----
// overhead sink: finds frame alignment, checks parity, extracts overhead
// assumes the link carries whole frames in order from an ofo_src peer
`timescale 1ns/1ps
module ofo_snk
  import ofo_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  ofo_link_if.snk          lk,
  input  wire logic        hold,
  input  wire logic        cn_mode,
  input  wire logic [5:0]  tti_rd_addr,
  output logic [7:0]       tti_rd_data,
  output logic [7:0]       pl_data,
  output logic             pl_valid,
  output logic             in_frame,
  output logic [7:0]       mfas,
  output logic [3:0]       bei_cnt,
  output logic             bip_err,
  output logic [3:0]       rem_bei,
  output logic             rem_biae,
  output logic             rx_bdi,
  output logic             rx_iae,
  output logic [2:0]       rx_stat
);

  typedef enum logic {
    ST_HUNT = 1'b0,
    ST_SYNC = 1'b1
  } ofo_st_e;

  ofo_st_e     st_q, st_d;
  ofo_col_t    col_q, col_d;
  ofo_row_t    row_q, row_d;
  logic [47:0] sh_q, sh_d;
  logic [2:0]  miss_q, miss_d;
  logic [1:0]  vld_q, vld_d;
  logic [7:0]  acc_q, acc_d, bip1_q, bip1_d, bip2_q, bip2_d;
  logic [7:0]  mfas_q, mfas_d, pl_q, pl_d;
  logic        plv_q, plv_d, err_q, err_d;
  logic [3:0]  cnt_q, cnt_d, rbei_q, rbei_d;
  logic        rbiae_q, rbiae_d, bdi_q, bdi_d, iae_q, iae_d;
  logic [2:0]  stat_q, stat_d;
  logic        rdy_q;
  logic [7:0]  tti_q;
  logic [7:0]  tti_mem [TTI_LEN];
  logic        take;
  logic [7:0]  b;
  logic [13:0] nxt;
  logic [4:0]  dec;

  function automatic logic [3:0] popcnt(input logic [7:0] v);
    popcnt = 4'h0;
    for (int i = 0; i < 8; i++)
      popcnt = popcnt + {3'h0, v[i]};
  endfunction

  assign take = lk.valid && rdy_q;
  assign b    = lk.data;
  assign nxt  = ofo_next_pos(col_q, row_q);
  assign dec  = ofo_bei_decode(b[7:4]);

  //--------------------------------------------------------------------
  // alignment and overhead extraction
  //--------------------------------------------------------------------
  always_comb
  begin
    st_d    = st_q;
    col_d   = col_q;
    row_d   = row_q;
    sh_d    = sh_q;
    miss_d  = miss_q;
    vld_d   = vld_q;
    acc_d   = acc_q;
    bip1_d  = bip1_q;
    bip2_d  = bip2_q;
    mfas_d  = mfas_q;
    pl_d    = pl_q;
    plv_d   = 1'b0;
    err_d   = 1'b0;
    cnt_d   = cnt_q;
    rbei_d  = rbei_q;
    rbiae_d = rbiae_q;
    bdi_d   = bdi_q;
    iae_d   = iae_q;
    stat_d  = stat_q;
    if (take)
    begin
      sh_d = {sh_q[39:0], b};
      col_d = nxt[11:0];
      row_d = nxt[13:12];
      case (st_q)
        ST_HUNT:
          if (sh_d == FAS_WORD)
          begin
            st_d = ST_SYNC;
            col_d = COL_MFAS;
            row_d = ROW_FIRST;
            miss_d = 3'h0;
            vld_d = 2'h0;
            acc_d = 8'h00;
          end
        ST_SYNC:
        begin
          pl_d = b;
          plv_d = !ofo_is_oh(col_q, row_q);
          if (col_q >= COL_PL_FIRST)
            acc_d = acc_q ^ b;
          if (row_q == ROW_FIRST)
            case (col_q)
              COL_FAS_LAST:
                if (sh_d != FAS_WORD)
                begin
                  miss_d = miss_q + 3'h1;
                  if (miss_d == MISS_LIMIT)
                    st_d = ST_HUNT;
                end
                else
                  miss_d = 3'h0;
              COL_MFAS:
                mfas_d = b;
              COL_BIP:
                if (vld_q[1])
                begin
                  cnt_d = popcnt(b ^ bip2_q);
                  err_d = (b != bip2_q);
                end
              COL_SM3:
              begin
                rbei_d = dec[3:0];
                rbiae_d = dec[4];
                bdi_d = b[3];
                iae_d = !cn_mode && b[2];
                stat_d = cn_mode ? b[2:0] : STAT_OK;
              end
              default:
                ;
            endcase
          if (col_q == COL_LAST && row_q == ROW_LAST)
          begin
            bip2_d = bip1_q;
            bip1_d = acc_q ^ b;
            acc_d = 8'h00;
            vld_d = {vld_q[0], 1'b1};
          end
        end
        default:
          st_d = ST_HUNT;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q    <= ST_HUNT;
      col_q   <= COL_FIRST;
      row_q   <= ROW_FIRST;
      sh_q    <= 48'h0;
      miss_q  <= 3'h0;
      vld_q   <= 2'h0;
      acc_q   <= 8'h00;
      bip1_q  <= 8'h00;
      bip2_q  <= 8'h00;
      mfas_q  <= 8'h00;
      pl_q    <= 8'h00;
      plv_q   <= 1'b0;
      err_q   <= 1'b0;
      cnt_q   <= 4'h0;
      rbei_q  <= 4'h0;
      rbiae_q <= 1'b0;
      bdi_q   <= 1'b0;
      iae_q   <= 1'b0;
      stat_q  <= 3'h0;
      rdy_q   <= 1'b0;
      tti_q   <= 8'h00;
    end
    else
    begin
      st_q    <= st_d;
      col_q   <= col_d;
      row_q   <= row_d;
      sh_q    <= sh_d;
      miss_q  <= miss_d;
      vld_q   <= vld_d;
      acc_q   <= acc_d;
      bip1_q  <= bip1_d;
      bip2_q  <= bip2_d;
      mfas_q  <= mfas_d;
      pl_q    <= pl_d;
      plv_q   <= plv_d;
      err_q   <= err_d;
      cnt_q   <= cnt_d;
      rbei_q  <= rbei_d;
      rbiae_q <= rbiae_d;
      bdi_q   <= bdi_d;
      iae_q   <= iae_d;
      stat_q  <= stat_d;
      // one cycle late; the source's two-entry buffer absorbs it
      rdy_q <= !hold;
      tti_q <= tti_mem[tti_rd_addr];
    end
  end

  // trace byte lands at the message index taken from the counter
  always_ff @(posedge sys_clk)
  begin
    if (take && st_q == ST_SYNC && row_q == ROW_FIRST && col_q == COL_TTI)
      tti_mem[mfas_q[5:0]] <= b;
  end

  assign lk.ready    = rdy_q;
  assign tti_rd_data = tti_q;
  assign pl_data     = pl_q;
  assign pl_valid    = plv_q;
  assign in_frame    = (st_q == ST_SYNC);
  assign mfas        = mfas_q;
  assign bei_cnt     = cnt_q;
  assign bip_err     = err_q;
  assign rem_bei     = rbei_q;
  assign rem_biae    = rbiae_q;
  assign rx_bdi      = bdi_q;
  assign rx_iae      = iae_q;
  assign rx_stat     = stat_q;

endmodule // ofo_snk

// ---- ofo_link_asserts.sv ----
// checker for the byte link between overhead source and sink
// assumes the link starts at row 1 column 1 after each reset
`timescale 1ns/1ps
module ofo_link_asserts
  import ofo_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] data,
  input wire logic       valid,
  input wire logic       ready
);
  logic       xfer;
  ofo_col_t   col_q, col_d;
  ofo_row_t   row_q, row_d;
  logic [7:0] mfas_q, mfas_d, par_q, par_d;
  logic [7:0] p1_q, p1_d, p2_q, p2_d;

  assign xfer = valid && ready;

  // ------------------------------------------------------------
  // frame position and parity tracker
  // ------------------------------------------------------------
  always_comb
  begin
    col_d  = col_q;
    row_d  = row_q;
    mfas_d = mfas_q;
    par_d  = par_q;
    p1_d   = p1_q;
    p2_d   = p2_q;
    if (xfer)
    begin
      col_d = col_q + 12'h001;
      if (col_q >= COL_PL_FIRST)
        par_d = par_q ^ data;
      if (col_q == COL_MFAS && row_q == ROW_FIRST)
        mfas_d = data + 8'h01;
      if (col_q == COL_LAST)
      begin
        col_d = COL_FIRST;
        row_d = row_q + 2'h1;
      end
      // parity of frame i waits two frames before it is expected
      if (col_q == COL_LAST && row_q == ROW_LAST)
      begin
        p1_d  = par_d;
        p2_d  = p1_q;
        par_d = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      col_q  <= COL_FIRST;
      row_q  <= ROW_FIRST;
      mfas_q <= 8'h00;
      par_q  <= 8'h00;
      p1_q   <= 8'h00;
      p2_q   <= 8'h00;
    end
    else
    begin
      col_q  <= col_d;
      row_q  <= row_d;
      mfas_q <= mfas_d;
      par_q  <= par_d;
      p1_q   <= p1_d;
      p2_q   <= p2_d;
    end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_lead_slot;
    xfer && row_q == ROW_FIRST
      && col_q >= COL_FIRST && col_q <= COL_FAS_LEAD;
  endsequence
  sequence s_trail_slot;
    xfer && row_q == ROW_FIRST
      && col_q > COL_FAS_LEAD && col_q <= COL_FAS_LAST;
  endsequence

  a_fas_lead_byte: assert property (s_lead_slot |-> data == FAS_LEAD)
    else $error("leading alignment byte wrong");
  a_fas_trail_byte: assert property (s_trail_slot |-> data == FAS_TRAIL)
    else $error("trailing alignment byte wrong");
  a_mfas_count_step: assert property (
    xfer && row_q == ROW_FIRST && col_q == COL_MFAS |-> data == mfas_q)
    else $error("multiframe byte did not step by one");
  a_bip_two_late: assert property (
    xfer && row_q == ROW_FIRST && col_q == COL_BIP |-> data == p2_q)
    else $error("parity byte does not match frame two back");
  a_spare_bytes_zero: assert property (
    xfer && row_q == ROW_FIRST && col_q > COL_SM3 && col_q <= COL_OH_LAST
    |-> data == 8'h00)
    else $error("overhead byte after monitoring field not zero");
  a_byte_stands: assert property (valid && !ready |=> valid && $stable(data))
    else $error("link byte changed before it was taken");
  a_valid_quiet_reset: assert property ($rose(rst_n) |-> !valid)
    else $error("link valid high at reset release");
  a_ready_quiet_reset: assert property ($rose(rst_n) |-> !ready)
    else $error("link ready high at reset release");
endmodule // ofo_link_asserts

// ---- otu_frame_alignment_sm_overhead_bench.sv ----
// bench: overhead source and sink joined over one link
// assumes a 125 MHz clock and one byte per accepted link beat
`timescale 1ns/1ps
module otu_frame_alignment_sm_overhead_bench;
  import ofo_pkg::*;

  logic       sys_clk, rst_n, pl_valid, pl_ready, tti_wr_en;
  logic [7:0] tti_wr_data, tx_mfas, tti_rd_data, rx_data;
  logic [7:0] pl_data = 8'h00;
  logic [5:0] tti_wr_addr, tti_rd_addr;
  logic       sink_sf, sink_iae, sink_biae, cn_mode, ais_en;
  logic [3:0] sink_bei_cnt, bei_cnt, rem_bei;
  logic       frame_start, rx_valid, in_frame, bip_err;
  logic       rem_biae, rx_bdi, rx_iae;
  logic       hold     = 1'b0;
  logic       take     = 1'b0;
  logic       bip_seen = 1'b0;
  logic [7:0] rx_mfas;
  logic [7:0] rx_exp   = 8'h00;
  logic [7:0] cyc      = 8'h00;
  logic [2:0] rx_stat;
  logic [9:0] exp_v;
  int         error_cnt;
  int         compares;
  // settings: cn, ais, defect, align error, biae, error count
  logic [8:0] set_tab [5] = '{9'h043, 9'h025, 9'h01c, 9'h162, 9'h180};
  // expected: defect, align error, biae, error code, status
  // an alignment error reads back as zero counted errors
  logic [9:0] exp_tab [5] = '{10'h219, 10'h181, 10'h141, 10'h282, 10'h007};

  ofo_link_if u_ofo_link_if (.sys_clk(sys_clk), .rst_n(rst_n));

  ofo_src u_ofo_src (.sys_clk(sys_clk), .rst_n(rst_n), .lk(u_ofo_link_if),
    .pl_data(pl_data), .pl_valid(pl_valid), .pl_ready(pl_ready),
    .tti_wr_en(tti_wr_en), .tti_wr_addr(tti_wr_addr),
    .tti_wr_data(tti_wr_data), .sink_sf(sink_sf), .sink_iae(sink_iae),
    .sink_bei_cnt(sink_bei_cnt), .sink_biae(sink_biae),
    .cn_mode(cn_mode), .ais_en(ais_en), .mfas(tx_mfas),
    .frame_start(frame_start));

  ofo_snk u_ofo_snk (.sys_clk(sys_clk), .rst_n(rst_n), .lk(u_ofo_link_if),
    .hold(hold), .cn_mode(cn_mode), .tti_rd_addr(tti_rd_addr),
    .tti_rd_data(tti_rd_data), .pl_data(rx_data), .pl_valid(rx_valid),
    .in_frame(in_frame), .mfas(rx_mfas), .bei_cnt(bei_cnt),
    .bip_err(bip_err), .rem_bei(rem_bei), .rem_biae(rem_biae),
    .rx_bdi(rx_bdi), .rx_iae(rx_iae), .rx_stat(rx_stat));

  ofo_link_asserts u_ofo_link_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
    .data(u_ofo_link_if.data), .valid(u_ofo_link_if.valid),
    .ready(u_ofo_link_if.ready));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_frame();
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    while (frame_start !== 1'b1 && n < 20000);
    if (frame_start !== 1'b1)
    begin
      error_cnt++;
      $display("unexpected frame_start: expected 1 seen %b", frame_start);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d, error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, payload feed, receiver stalls
  // ------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // pl_ready is combinational, so the handshake is judged before the edge
  always @(negedge sys_clk)
    take = pl_valid && pl_ready && rst_n;

  always @(posedge sys_clk)
  begin
    #1;
    cyc = cyc + 8'h01;
    // short stalls fill the source buffer until payload is refused
    hold = (cyc < 8'h08);
    if (take)
      pl_data = pl_data + 8'h01;
    if (rx_valid === 1'b1)
    begin
      chk("payload byte", rx_exp, rx_data);
      rx_exp = rx_exp + 8'h01;
    end
    if (bip_err === 1'b1)
      bip_seen = 1'b1;
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    $display("watchdog expired");
    report_and_stop();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    pl_valid = 1'b0;
    tti_wr_en = 1'b0;
    tti_wr_addr = 6'h00;
    tti_wr_data = 8'h00;
    tti_rd_addr = 6'h00;
    error_cnt = 0;
    compares = 0;
    {cn_mode, ais_en, sink_sf, sink_iae, sink_biae, sink_bei_cnt} = set_tab[0];
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    pl_valid = 1'b1;
    for (int a = 0; a < 64; a++)
    begin
      tti_wr_en = 1'b1;
      tti_wr_addr = 6'(a);
      tti_wr_data = {2'b10, 6'(a)};
      @(posedge sys_clk);
      #1;
    end
    tti_wr_en = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      wait_frame();
      exp_v = exp_tab[k];
      chk("defect bit", 8'(exp_v[9]), 8'(rx_bdi));
      chk("align error bit", 8'(exp_v[8]), 8'(rx_iae));
      chk("biae flag", 8'(exp_v[7]), 8'(rem_biae));
      chk("error code", 8'(exp_v[6:3]), 8'(rem_bei));
      chk("status", 8'(exp_v[2:0]), 8'(rx_stat));
      chk("frame counter", 8'(k), rx_mfas);
      chk("source counter", 8'(k + 1), tx_mfas);
      chk("in frame", 8'h01, 8'(in_frame));
      chk("parity errors", 8'h00, 8'(bei_cnt));
      chk("parity flag", 8'h00, 8'(bip_seen));
      if (k < 4)
        {cn_mode, ais_en, sink_sf, sink_iae, sink_biae, sink_bei_cnt} =
          set_tab[k + 1];
      $display("test frame %0d finished", k);
    end
    for (int a = 0; a < 5; a++)
    begin
      tti_rd_addr = 6'(a);
      @(posedge sys_clk);
      #1;
      chk("trace byte", {2'b10, 6'(a)}, tti_rd_data);
    end
    $display("test trace finished");
    report_and_stop();
  end
endmodule // otu_frame_alignment_sm_overhead_bench
